//--- core/smul_pkg.sv
// Package for the pipelined signed 18x18 multiplier with operand cascade.
// Assumes a single AHB-Lite master with 32-bit data and word-only transfers.

package smul_pkg;

    // ==========================================================
    // Datapath widths
    // ==========================================================
    localparam int OPERAND_W = 18;
    localparam int PRODUCT_W = 36;
    localparam int BUS_W     = 32;
    localparam int ADDR_W    = 32;
    localparam int INV_W     = 6;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [7:0] REG_POLARITY = 8'h00;  // Control polarity inversion, RW
    localparam logic [7:0] REG_PROD_LO  = 8'h04;  // Product bits 31..0, RO
    localparam logic [7:0] REG_PROD_HI  = 8'h08;  // Product bits 35..32, RO
    localparam logic [7:0] REG_CHAIN    = 8'h0C;  // Applied second operand, RO
    localparam logic [7:0] REG_CONFIG   = 8'h10;  // Build options, RO

    // ==========================================================
    // Polarity register field positions and reset value
    // ==========================================================
    localparam int INV_FIRST_CE    = 0;
    localparam int INV_FIRST_CLR   = 1;
    localparam int INV_SECOND_CE   = 2;
    localparam int INV_SECOND_CLR  = 3;
    localparam int INV_PRODUCT_CE  = 4;
    localparam int INV_PRODUCT_CLR = 5;
    localparam logic [INV_W-1:0] POLARITY_RESET = 6'h00;

    // ==========================================================
    // Config register field positions
    // ==========================================================
    localparam int CFG_FIRST   = 0;
    localparam int CFG_SECOND  = 1;
    localparam int CFG_PRODUCT = 2;
    localparam int CFG_CASCADE = 3;
    localparam int CFG_CLK_INV = 4;

    // ==========================================================
    // Bus codes
    // ==========================================================
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;
    localparam logic [BUS_W-1:0] BUS_ZERO = 32'h0000_0000;

    // Second-operand source choice
    typedef enum logic { SMUL_SRC_DIRECT, SMUL_SRC_CASCADE } smul_src_t;

    // One stage's raw enable and clear pins
    typedef struct packed {
        logic ce;
        logic clr;
    } smul_stage_ctl_t;

    // AHB-Lite request side
    typedef struct packed {
        logic              hsel;
        logic [ADDR_W-1:0] haddr;
        logic [1:0]        htrans;
        logic              hwrite;
        logic [2:0]        hsize;
        logic              hready;
        logic [BUS_W-1:0]  hwdata;
    } smul_ahb_req_t;

    // AHB-Lite answer side
    typedef struct packed {
        logic             hreadyout;
        logic             hresp;
        logic [BUS_W-1:0] hrdata;
    } smul_ahb_rsp_t;

endpackage

//--- core/smul_mult18.sv
// Signed 18x18 multiplier block with optional operand and product stages,
// a cascade path for the second operand, and an AHB-Lite register slave.
// Assumes the neighbour below drives the chain input (tie zero at the bottom)
// and that all pins are synchronous to clk_sys.
//
// Implementation choices: the AHB-Lite register port and the register addresses.

`timescale 1ns/1ps

module smul_mult18
    import smul_pkg::*;
#(
    parameter bit        FIRST_STAGE_EN   = 1'b1,
    parameter bit        SECOND_STAGE_EN  = 1'b1,
    parameter bit        PRODUCT_STAGE_EN = 1'b1,
    parameter smul_src_t CHAIN_SOURCE     = SMUL_SRC_DIRECT,
    parameter bit        CLK_INVERT       = 1'b0
)
(
    // Clock and configuration reset
    input  wire logic                   clk_sys,
    input  wire logic                   nrst,
    // Operands and cascade
    input  wire logic [OPERAND_W-1:0]   operand_a,
    input  wire logic [OPERAND_W-1:0]   operand_b,
    input  wire logic [OPERAND_W-1:0]   chain_operand_in,
    output logic      [OPERAND_W-1:0]   chain_operand_out,
    // Stage controls
    input  wire smul_stage_ctl_t        first_stage_ctl,
    input  wire smul_stage_ctl_t        second_stage_ctl,
    input  wire smul_stage_ctl_t        product_stage_ctl,
    // Product
    output logic      [PRODUCT_W-1:0]   product,
    // Register bus
    input  wire smul_ahb_req_t          ahb_req,
    output smul_ahb_rsp_t               ahb_rsp
);

    // ==========================================================
    // Clock polarity
    // ==========================================================
    // Inversion is a build option only; a runtime switch would glitch the clock.
    logic clk_int;
    assign clk_int = clk_sys ^ CLK_INVERT;

    // ==========================================================
    // Declarations
    // ==========================================================
    logic [INV_W-1:0]     polarity_q;
    logic                 first_ce;
    logic                 first_clr;
    logic                 second_ce;
    logic                 second_clr;
    logic                 product_ce;
    logic                 product_clr;
    logic [OPERAND_W-1:0] first_stage_q;
    logic [OPERAND_W-1:0] second_stage_q;
    logic [PRODUCT_W-1:0] product_stage_q;
    logic [OPERAND_W-1:0] second_src;
    logic [OPERAND_W-1:0] mult_a;
    logic [OPERAND_W-1:0] mult_b;
    logic [PRODUCT_W-1:0] mult_p;
    logic [PRODUCT_W-1:0] ext_a;
    logic [PRODUCT_W-1:0] ext_b;
    logic                 wr_pend_q;
    logic [7:0]           wr_addr_q;
    logic [BUS_W-1:0]     rdata_q;
    logic                 addr_phase;
    logic [BUS_W-1:0]     rd_value;

    // ==========================================================
    // Effective stage controls
    // ==========================================================
    // Each control is XORed with its inversion bit from the polarity register
    assign first_ce    = first_stage_ctl.ce    ^ polarity_q[INV_FIRST_CE];
    assign first_clr   = first_stage_ctl.clr   ^ polarity_q[INV_FIRST_CLR];
    assign second_ce   = second_stage_ctl.ce   ^ polarity_q[INV_SECOND_CE];
    assign second_clr  = second_stage_ctl.clr  ^ polarity_q[INV_SECOND_CLR];
    assign product_ce  = product_stage_ctl.ce  ^ polarity_q[INV_PRODUCT_CE];
    assign product_clr = product_stage_ctl.clr ^ polarity_q[INV_PRODUCT_CLR];

    // ==========================================================
    // Second operand source
    // ==========================================================
    // Source choice is fixed at build time, as in a configured fabric block
    assign second_src = (CHAIN_SOURCE == SMUL_SRC_CASCADE) ? chain_operand_in
                                                           : operand_b;

    // ==========================================================
    // Operand stages
    // ==========================================================
    // First operand stage: clear beats enable, otherwise hold
    always_ff @(posedge clk_int or negedge nrst)
    begin
        if (!nrst)
            first_stage_q <= '0;
        else if (first_clr)
            first_stage_q <= '0;
        else if (first_ce)
            first_stage_q <= operand_a;
    end

    // Second operand stage: loads the selected source so the chain shifts
    always_ff @(posedge clk_int or negedge nrst)
    begin
        if (!nrst)
            second_stage_q <= '0;
        else if (second_clr)
            second_stage_q <= '0;
        else if (second_ce)
            second_stage_q <= second_src;
    end

    // Bypass muxes; an absent stage's pins only reach a register nobody reads
    assign mult_a = FIRST_STAGE_EN  ? first_stage_q  : operand_a;
    assign mult_b = SECOND_STAGE_EN ? second_stage_q : second_src;

    // Cascade output shows exactly what the multiplier sees
    assign chain_operand_out = mult_b;

    // ==========================================================
    // Multiplier and product stage
    // ==========================================================
    // Signed product at full width; 18x18 cannot overflow 36 bits.
    // Operands are sign-extended first so no tool can size the multiply at 18 bits.
    assign ext_a  = {{(PRODUCT_W-OPERAND_W){mult_a[OPERAND_W-1]}}, mult_a};
    assign ext_b  = {{(PRODUCT_W-OPERAND_W){mult_b[OPERAND_W-1]}}, mult_b};
    assign mult_p = $signed(ext_a) * $signed(ext_b);

    // Product stage register
    always_ff @(posedge clk_int or negedge nrst)
    begin
        if (!nrst)
            product_stage_q <= '0;
        else if (product_clr)
            product_stage_q <= '0;
        else if (product_ce)
            product_stage_q <= mult_p;
    end

    // Without the product stage, timing is whatever the input stages give
    assign product = PRODUCT_STAGE_EN ? product_stage_q : mult_p;

    // ==========================================================
    // AHB-Lite slave
    // ==========================================================
    // Zero wait states: the slave never stalls, so hreadyout is constant high
    assign addr_phase = ahb_req.hsel && ahb_req.hready && (ahb_req.htrans == HTRANS_NONSEQ);

    // Read mux for the addressed register; unmapped offsets read zero
    always_comb
    begin
        rd_value = BUS_ZERO;
        unique case (ahb_req.haddr[7:0])
            REG_POLARITY: rd_value = {{(BUS_W-INV_W){1'b0}}, polarity_q};
            REG_PROD_LO:  rd_value = product[BUS_W-1:0];
            REG_PROD_HI:  rd_value = {{(2*BUS_W-PRODUCT_W){1'b0}}, product[PRODUCT_W-1:BUS_W]};
            REG_CHAIN:    rd_value = {{(BUS_W-OPERAND_W){1'b0}}, chain_operand_out};
            REG_CONFIG:
            begin
                rd_value[CFG_FIRST]   = FIRST_STAGE_EN;
                rd_value[CFG_SECOND]  = SECOND_STAGE_EN;
                rd_value[CFG_PRODUCT] = PRODUCT_STAGE_EN;
                rd_value[CFG_CASCADE] = (CHAIN_SOURCE == SMUL_SRC_CASCADE);
                rd_value[CFG_CLK_INV] = CLK_INVERT;
            end
            default:      rd_value = BUS_ZERO;
        endcase
    end

    // Address phase capture; read data is latched so it stands in the data phase
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            rdata_q   <= BUS_ZERO;
        end
        else
        begin
            wr_pend_q <= addr_phase && ahb_req.hwrite;
            if (addr_phase)
                wr_addr_q <= ahb_req.haddr[7:0];
            if (addr_phase && !ahb_req.hwrite)
                rdata_q <= rd_value;
        end
    end

    // Polarity register written in the data phase
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            polarity_q <= POLARITY_RESET;
        else if (wr_pend_q && (wr_addr_q == REG_POLARITY))
            polarity_q <= ahb_req.hwdata[INV_W-1:0];
    end

    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp     = HRESP_OKAY;
    assign ahb_rsp.hrdata    = rdata_q;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk_int); endclocking
    default disable iff (!nrst);

    sequence s_first_load;
        first_ce && !first_clr;
    endsequence

    sequence s_second_idle;
        !second_ce && !second_clr;
    endsequence

    sequence s_first_idle;
        !first_ce && !first_clr;
    endsequence

    chk_full_product: assert property (
        $signed(mult_p) ==
        $signed({{(PRODUCT_W-OPERAND_W){mult_a[OPERAND_W-1]}}, mult_a}) *
        $signed({{(PRODUCT_W-OPERAND_W){mult_b[OPERAND_W-1]}}, mult_b}))
        else $error("product not full signed width");

    chk_first_load: assert property (
        s_first_load |=> first_stage_q == $past(operand_a))
        else $error("first stage missed a load");

    chk_clear_wins: assert property (
        (first_clr || second_clr) |=> (!$past(first_clr) || first_stage_q == '0) &&
                                      (!$past(second_clr) || second_stage_q == '0))
        else $error("clear did not zero the stage");

    chk_second_hold: assert property (
        s_second_idle |=> $stable(second_stage_q))
        else $error("second stage changed while idle");

    chk_source_load: assert property (
        (second_ce && !second_clr) |=> second_stage_q ==
            ((CHAIN_SOURCE == SMUL_SRC_CASCADE) ? $past(chain_operand_in) : $past(operand_b)))
        else $error("second stage loaded the wrong source");

    chk_chain_applied: assert property (
        SECOND_STAGE_EN |-> chain_operand_out == second_stage_q)
        else $error("chain output differs from applied operand");

    // Without the second stage the chain must show the raw selected pin
    chk_chain_bypass: assert property (
        !SECOND_STAGE_EN |-> chain_operand_out ==
            ((CHAIN_SOURCE == SMUL_SRC_CASCADE) ? chain_operand_in : operand_b))
        else $error("bypassed chain output differs from selected pin");

    chk_product_reg: assert property (
        PRODUCT_STAGE_EN && !product_ce && !product_clr |=> $stable(product))
        else $error("registered product moved without enable");

    chk_product_follow: assert property (
        PRODUCT_STAGE_EN && product_ce && !product_clr ##1 !product_clr
        |-> product == $past(mult_p))
        else $error("registered product lost its load");

    chk_polarity_map: assert property (
        polarity_q[INV_FIRST_CE] |-> first_ce == !first_stage_ctl.ce)
        else $error("enable polarity inversion not applied");

    chk_bypass_first: assert property (
        !FIRST_STAGE_EN |-> mult_a == operand_a)
        else $error("absent first stage still in path");

    // Sign of a non-zero product follows the operand signs; a cut product breaks it
    chk_product_sign: assert property (
        (mult_a != '0 && mult_b != '0) |->
            mult_p[PRODUCT_W-1] == (mult_a[OPERAND_W-1] ^ mult_b[OPERAND_W-1]))
        else $error("product sign wrong for its operands");

    chk_first_hold: assert property (
        s_first_idle |=> $stable(first_stage_q))
        else $error("first stage changed while idle");

    chk_product_clear: assert property (
        product_clr |=> product_stage_q == '0)
        else $error("product clear did not zero the stage");

    // A registered cascade column moves the value up one block per enabled edge
    chk_chain_shift: assert property (
        (SECOND_STAGE_EN && (CHAIN_SOURCE == SMUL_SRC_CASCADE) && second_ce && !second_clr)
        |=> chain_operand_out == $past(chain_operand_in))
        else $error("registered chain did not shift");

    chk_bypass_second: assert property (
        !SECOND_STAGE_EN |-> mult_b == ((CHAIN_SOURCE == SMUL_SRC_CASCADE) ? chain_operand_in
                                                                          : operand_b))
        else $error("absent second stage still in path");

    chk_product_bypass: assert property (
        !PRODUCT_STAGE_EN |-> product == mult_p)
        else $error("absent product stage still in path");

    chk_polarity_clear: assert property (
        polarity_q[INV_PRODUCT_CLR] |-> product_clr == !product_stage_ctl.clr)
        else $error("clear polarity inversion not applied");

    // ==========================================================
    // Bus checks
    // ==========================================================
    // The bus always runs on the plain clock, whatever the datapath polarity
    chk_polarity_write: assert property (@(posedge clk_sys) disable iff (!nrst)
        (wr_pend_q && (wr_addr_q == REG_POLARITY)) |=>
            polarity_q == $past(ahb_req.hwdata[INV_W-1:0]))
        else $error("polarity write did not land");

    chk_read_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
        (addr_phase && !ahb_req.hwrite) |=> ahb_rsp.hrdata == $past(rd_value))
        else $error("read data not captured in address phase");

    chk_ready_high: assert property (@(posedge clk_sys) disable iff (!nrst)
        ahb_rsp.hreadyout && (ahb_rsp.hresp == HRESP_OKAY))
        else $error("slave stalled or answered with an error");

endmodule

//--- sim/smul_nbr_model.sv
// Model of the multiplier block below, seen only through its chain output.
// Assumes one shared clock and the active-low asynchronous reset of the column.

`timescale 1ns/1ps

module smul_nbr_model
    import smul_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    // Fabric side of the neighbour
    input  wire logic                 shift_en,
    input  wire logic [OPERAND_W-1:0] seed_val,
    // Chain toward the block above
    output logic      [OPERAND_W-1:0] chain_operand_out
);

    // ==========================================================
    // Registered second-operand stage of the neighbour
    // ==========================================================
    // Shifts a fresh value each enabled edge so a wrongly routed source shows up
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            chain_operand_out <= '0;
        else if (shift_en)
            chain_operand_out <= seed_val;
    end

endmodule

//--- sim/smul_mult18_tb_top.sv
// Self-checking bench: registered direct block over a neighbour model, with a
// combinational cascade block stacked above it. Assumes a 40 MHz clk_sys.

`timescale 1ns/1ps

module smul_mult18_tb_top;
    import smul_pkg::*;

    // ==========================================================
    // Signals
    // ==========================================================
    logic                 clk_sys = 1'b0;
    logic                 nrst = 1'b0;
    logic                 chk_en = 1'b0;
    logic                 nbr_shift;
    logic [OPERAND_W-1:0] op_a, op_b, op_a2, op_b2, nbr_seed;
    logic [OPERAND_W-1:0] chain_lo, chain_mid, chain_top, chain_r, ea_q, eb_q, er_q;
    logic [PRODUCT_W-1:0] prod, prod_c, prod_r, ep_q;
    logic [INV_W-1:0]     inv;
    logic [BUS_W-1:0]     rd;
    smul_stage_ctl_t      ctl_a, ctl_b, ctl_p, ctl_c, ctl_r;
    smul_ahb_req_t        req;
    smul_ahb_rsp_t        rsp;
    int                   n_fail = 0;
    int                   n_checks = 0;
    integer               seed = 32'h7CB8_9584;

    always #12.5 clk_sys = ~clk_sys;

    // ==========================================================
    // Blocks under test and neighbour
    // ==========================================================
    smul_nbr_model nbr (.clk_sys(clk_sys), .nrst(nrst), .shift_en(nbr_shift),
                        .seed_val(nbr_seed), .chain_operand_out(chain_lo));

    smul_mult18 dut (.clk_sys(clk_sys), .nrst(nrst), .operand_a(op_a), .operand_b(op_b),
                     .chain_operand_in(chain_lo), .chain_operand_out(chain_mid),
                     .first_stage_ctl(ctl_a), .second_stage_ctl(ctl_b),
                     .product_stage_ctl(ctl_p), .product(prod), .ahb_req(req), .ahb_rsp(rsp));

    // No stages, cascade source: its bus is unused, so it is tied off
    smul_mult18 #(.FIRST_STAGE_EN(1'b0), .SECOND_STAGE_EN(1'b0), .PRODUCT_STAGE_EN(1'b0),
                  .CHAIN_SOURCE(SMUL_SRC_CASCADE)) dut_c
        (.clk_sys(clk_sys), .nrst(nrst), .operand_a(op_a2), .operand_b(op_b2),
         .chain_operand_in(chain_mid), .chain_operand_out(chain_top),
         .first_stage_ctl(ctl_c), .second_stage_ctl(ctl_c), .product_stage_ctl(ctl_c),
         .product(prod_c), .ahb_req('0), .ahb_rsp());

    // Registered cascade block on top: its second stage shifts the column value
    smul_mult18 #(.FIRST_STAGE_EN(1'b0), .SECOND_STAGE_EN(1'b1), .PRODUCT_STAGE_EN(1'b0),
                  .CHAIN_SOURCE(SMUL_SRC_CASCADE)) dut_r
        (.clk_sys(clk_sys), .nrst(nrst), .operand_a(op_a2), .operand_b(op_b2),
         .chain_operand_in(chain_top), .chain_operand_out(chain_r),
         .first_stage_ctl(ctl_c), .second_stage_ctl(ctl_r), .product_stage_ctl(ctl_c),
         .product(prod_r), .ahb_req('0), .ahb_rsp());

    // ==========================================================
    // Reference functions
    // ==========================================================
    function automatic logic [PRODUCT_W-1:0] mul(input logic [17:0] a, input logic [17:0] b);
        logic signed [PRODUCT_W-1:0] r;
        r = $signed(a) * $signed(b);
        return r;
    endfunction

    // Corner operands mixed into random ones; extremes give the widest product
    function automatic logic [OPERAND_W-1:0] pick();
        int r;
        r = $random(seed);
        if (r[2:0] == 3'h0)
            return r[3] ? 18'h20000 : 18'h1FFFF;
        if (r[2:0] == 3'h1)
            return {{10{r[7]}}, r[7:0]};
        if (r[2:0] == 3'h2)
            return {1'b0, r[16:0]};
        return r[17:0];
    endfunction

    function automatic smul_stage_ctl_t rnd_ctl();
        smul_stage_ctl_t c;
        int r;
        r = $random(seed);
        c.ce = r[0];
        c.clr = (r[3:1] == 3'h0);
        return c;
    endfunction

    // Expected stage contents, polarity applied as the control register says
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ea_q <= '0;
            eb_q <= '0;
            ep_q <= '0;
            er_q <= '0;
        end
        else
        begin
            if (ctl_a.clr ^ inv[INV_FIRST_CLR]) ea_q <= '0;
            else if (ctl_a.ce ^ inv[INV_FIRST_CE]) ea_q <= op_a;
            if (ctl_b.clr ^ inv[INV_SECOND_CLR]) eb_q <= '0;
            else if (ctl_b.ce ^ inv[INV_SECOND_CE]) eb_q <= op_b;
            if (ctl_p.clr ^ inv[INV_PRODUCT_CLR]) ep_q <= '0;
            else if (ctl_p.ce ^ inv[INV_PRODUCT_CE]) ep_q <= mul(ea_q, eb_q);
            // Top block takes the middle stage's old value: one block per enabled edge
            if (ctl_r.clr) er_q <= '0;
            else if (ctl_r.ce) er_q <= eb_q;
        end
    end

    // ==========================================================
    // Checking and closing
    // ==========================================================
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        if (n_fail == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Outputs are settled by the falling edge
    always @(negedge clk_sys)
    begin
        if (nrst && chk_en)
        begin
            check(prod, ep_q);
            check(chain_mid, eb_q);
            check(prod_c, mul(op_a2, eb_q));
            check(chain_top, eb_q);
            check(chain_r, er_q);
            check(prod_r, mul(op_a2, er_q));
            check(rsp.hresp, HRESP_OKAY);
        end
    end

    // ==========================================================
    // Stimulus
    // ==========================================================
    task automatic run_random(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            op_a <= pick();  // no memory beside, no shared routing
            op_b <= pick();
            op_a2 <= pick();
            op_b2 <= pick();
            nbr_seed <= pick();
            nbr_shift <= 1'($random(seed));
            ctl_a <= rnd_ctl();
            ctl_b <= rnd_ctl();
            ctl_p <= rnd_ctl();
            ctl_c <= rnd_ctl();
            ctl_r <= rnd_ctl();
        end
    endtask

    // Wait on ready under a bound; running out ends the run as a failure
    task automatic wait_ready;
        int k;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (rsp.hreadyout !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            n_fail++;
            finish_test();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk_sys);
        req.hsel <= 1'b1;
        req.haddr <= {24'h000000, addr};
        req.htrans <= HTRANS_NONSEQ;
        req.hwrite <= wr;
        req.hsize <= 3'h2;
        wait_ready();
        req.htrans <= 2'h0;
        req.hsel <= 1'b0;
        req.hwdata <= wd;
        wait_ready();
        rd = rsp.hrdata;
    endtask

    initial
    begin
        {op_a, op_b, op_a2, op_b2, nbr_seed, nbr_shift} = '0;
        {ctl_a, ctl_b, ctl_p, ctl_c, ctl_r} = '0;
        req = '0;
        req.hready = 1'b1;  // Single slave whose ready is always high
        inv = '0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        chk_en <= 1'b1;
        run_random(400);
        // Hold every stage of dut so live product reads stay stable
        @(posedge clk_sys);
        {ctl_a, ctl_b, ctl_p} <= '0;
        bus(1'b0, REG_CONFIG, BUS_ZERO);
        check(rd, 32'h0000_0007);
        bus(1'b0, REG_POLARITY, BUS_ZERO);
        check(rd, {26'h0000000, POLARITY_RESET});
        bus(1'b0, REG_PROD_LO, BUS_ZERO);
        check(rd, ep_q[31:0]);
        bus(1'b0, REG_PROD_HI, BUS_ZERO);
        check(rd, {28'h0000000, ep_q[35:32]});
        bus(1'b0, REG_CHAIN, BUS_ZERO);
        check(rd, {14'h0000, eb_q});
        bus(1'b0, 8'h20, BUS_ZERO);
        check(rd, BUS_ZERO);
        // Invert every enable and clear, then run with the new polarity
        bus(1'b1, REG_POLARITY, 32'h0000_003F);
        inv <= 6'h3F;
        bus(1'b0, REG_POLARITY, BUS_ZERO);
        check(rd, 32'h0000_003F);
        run_random(300);
        bus(1'b1, REG_POLARITY, BUS_ZERO);
        inv <= 6'h00;
        run_random(100);
        finish_test();
    end

endmodule
